// [mbs_brake_seq.sv]
// Mechanical brake sequencer: state machine driving brake relay and requests
`timescale 1ns/1ps
`include "mbs_defs.svh"

// Function
// RL1: Disabled: enabled bit 0, open bit 1
// RL2: Opening sets hold and open until delay
// RL3: Open keeps brake open, hold cleared
// RL4: Closing wait ramps down until speed low
// RL5: Closing delay drops open, keeps ramp-down
// RL6: Closed keeps brake shut, modulation not needed
// RL7: Enable falling to zero forces disabled
// RL8: Enable rising leaves disabled, resumes sequencing
// RL9: Run status bit low changes state
// RL10: Start command decides open and close
// RL11: Brake command is status word bit 0
// RL12: Opening becomes open only after delay
// RL13: Slow speed moves wait to delay
// RL14: Close request waits; open request reopens
// RL15: Hold and ramp requests always readable
// RL16: Delays are reloaded clock tick counters
module mbs_brake_seq
  import mbs_pkg::*;
#(
  parameter int SPEED_W = `MBS_SPEED_W,
  parameter int DELAY_W = `MBS_DELAY_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Configuration
  input wire logic brake_enable_in,
  input wire logic [DELAY_W-1:0] open_delay_in,
  input wire logic [DELAY_W-1:0] close_delay_in,
  input wire logic [SPEED_W-1:0] close_level_in,
  // Drive status
  input wire logic start_cmd_in,
  input wire logic run_status_in,
  input wire logic signed [SPEED_W-1:0] motor_speed_in,
  // Brake status word and its individual bits
  output logic [`MBS_STAT_W-1:0] brake_status_out,
  output logic brake_open_out,
  output logic hold_req_out,
  output logic ramp_req_out,
  output logic enabled_out,
  // Current state
  output logic [`MBS_STATE_W-1:0] state_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mbs_state_t state_reg;
  mbs_state_t state_next;
  logic [`MBS_STAT_W-1:0] stat_next;
  logic open_load;
  logic close_load;
  logic open_expired;
  logic close_expired;
  logic speed_below;
  logic open_req;
  logic close_req;

  // ----------------------------------------------------------------
  // Status word decode
  // ----------------------------------------------------------------
  // Bit 1 is left at zero in every state
  function automatic logic [`MBS_STAT_W-1:0] stat_of(input mbs_state_t s);
    logic [`MBS_STAT_W-1:0] w;
    w = '0;
    case (s)
      MBS_DISABLED: begin
        w[`MBS_BIT_OPEN] = 1'b1; // RL1
      end
      MBS_OPENING: begin
        w[`MBS_BIT_OPEN] = 1'b1; // RL2
        w[`MBS_BIT_HOLD] = 1'b1; // RL2
        w[`MBS_BIT_EN] = 1'b1;
      end
      MBS_OPEN: begin
        w[`MBS_BIT_OPEN] = 1'b1; // RL3
        w[`MBS_BIT_EN] = 1'b1;
      end
      MBS_CLOSE_WAIT: begin
        w[`MBS_BIT_OPEN] = 1'b1; // RL4
        w[`MBS_BIT_RAMP] = 1'b1; // RL4
        w[`MBS_BIT_EN] = 1'b1;
      end
      MBS_CLOSE_DELAY: begin
        w[`MBS_BIT_RAMP] = 1'b1; // RL5
        w[`MBS_BIT_EN] = 1'b1;
      end
      MBS_CLOSED: begin
        w[`MBS_BIT_EN] = 1'b1; // RL6
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // The start command alone asks for opening or closing
  assign open_req = start_cmd_in; // RL10
  assign close_req = !start_cmd_in; // RL10

  // ----------------------------------------------------------------
  // Timers and speed compare
  // ----------------------------------------------------------------
  // Loaded on the edge that enters the state, so counting starts there
  assign open_load = (state_next == MBS_OPENING) && // RL16
                     (state_reg != MBS_OPENING);
  assign close_load = (state_next == MBS_CLOSE_DELAY) && // RL16
                      (state_reg != MBS_CLOSE_DELAY);

  mbs_delay_timer #(
    .DELAY_W(DELAY_W)
  ) u_open_timer (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(open_load),
    .delay_in(open_delay_in),
    .expired_out(open_expired)
  );

  mbs_delay_timer #(
    .DELAY_W(DELAY_W)
  ) u_close_timer (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(close_load),
    .delay_in(close_delay_in),
    .expired_out(close_expired)
  );

  mbs_speed_cmp #(
    .SPEED_W(SPEED_W)
  ) u_speed_cmp (
    .speed_in(motor_speed_in),
    .level_in(close_level_in),
    .below_out(speed_below)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Losing run status while the brake is open drops it at once: the
  // drive no longer holds the load, so waiting for a ramp is pointless
  always_comb begin
    state_next = state_reg;
    if (!brake_enable_in) begin
      state_next = MBS_DISABLED; // RL7
    end else begin
      case (state_reg)
        MBS_DISABLED: begin
          state_next = MBS_CLOSED; // RL8
        end
        MBS_CLOSED: begin
          if (open_req && run_status_in) begin
            state_next = MBS_OPENING; // RL14
          end
        end
        MBS_OPENING: begin
          if (!run_status_in) begin
            state_next = MBS_CLOSE_DELAY; // RL9
          end else if (close_req) begin
            state_next = MBS_CLOSE_WAIT;
          end else if (open_expired) begin
            state_next = MBS_OPEN; // RL12
          end
        end
        MBS_OPEN: begin
          if (!run_status_in) begin
            state_next = MBS_CLOSE_DELAY; // RL9
          end else if (close_req) begin
            state_next = MBS_CLOSE_WAIT; // RL14
          end
        end
        MBS_CLOSE_WAIT: begin
          if (!run_status_in) begin
            state_next = MBS_CLOSE_DELAY; // RL9
          end else if (open_req) begin
            state_next = MBS_OPENING; // RL14
          end else if (speed_below) begin
            state_next = MBS_CLOSE_DELAY; // RL13
          end
        end
        MBS_CLOSE_DELAY: begin
          if (open_req && run_status_in) begin
            state_next = MBS_OPENING; // RL14
          end else if (close_expired) begin
            state_next = MBS_CLOSED; // RL5
          end
        end
        default: begin
          state_next = MBS_DISABLED;
        end
      endcase
    end
  end

  assign stat_next = stat_of(state_next);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset lands in closed with the relay off; a low enable then
  // moves to disabled one edge later
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= MBS_CLOSED;
      state_out <= `MBS_ST_CLOSED;
    end else begin
      state_reg <= state_next;
      state_out <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Outputs follow state_next so they change on the same edge as state
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      brake_status_out <= `MBS_STAT_RST;
      brake_open_out <= 1'b0;
      hold_req_out <= 1'b0;
      ramp_req_out <= 1'b0;
      enabled_out <= 1'b1;
    end else begin
      brake_status_out <= stat_next; // RL15
      brake_open_out <= stat_next[`MBS_BIT_OPEN]; // RL11
      hold_req_out <= stat_next[`MBS_BIT_HOLD]; // RL15
      ramp_req_out <= stat_next[`MBS_BIT_RAMP]; // RL15
      enabled_out <= stat_next[`MBS_BIT_EN];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_disable_forces: assert property ( // RL7
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    !brake_enable_in |=> (state_reg == MBS_DISABLED) && !enabled_out &&
      brake_open_out
  ) else $error("low enable did not reach disabled");

  chk_disabled_outputs: assert property ( // RL1
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_DISABLED) |->
      !brake_status_out[`MBS_BIT_EN] && brake_status_out[`MBS_BIT_OPEN]
  ) else $error("disabled state shows wrong status");

  chk_enable_resume: assert property ( // RL8
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_DISABLED) && brake_enable_in |=>
      (state_reg == MBS_CLOSED) && enabled_out && !brake_open_out
  ) else $error("enable did not leave disabled");

  chk_opening_hold: assert property ( // RL2
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_OPENING) |-> hold_req_out && brake_open_out &&
      !ramp_req_out
  ) else $error("opening without hold and open");

  chk_open_free: assert property ( // RL3
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_OPEN) |-> brake_open_out && !hold_req_out
  ) else $error("open state holds or closes brake");

  chk_wait_ramp: assert property ( // RL4
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSE_WAIT) |-> ramp_req_out && brake_open_out
  ) else $error("closing wait without ramp or open");

  chk_delay_drop: assert property ( // RL5
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSE_DELAY) |-> !brake_open_out && ramp_req_out
  ) else $error("closing delay keeps brake open");

  chk_closed_shut: assert property ( // RL6
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSED) |-> !brake_open_out
  ) else $error("closed state opens brake");

  chk_run_lost: assert property ( // RL9
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    brake_enable_in && !run_status_in && brake_open_out &&
      (state_reg != MBS_DISABLED) |=> (state_reg == MBS_CLOSE_DELAY)
  ) else $error("run status loss did not drop brake");

  chk_start_opens: assert property ( // RL10
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    brake_enable_in && start_cmd_in && run_status_in &&
      (state_reg == MBS_CLOSED) |=> (state_reg == MBS_OPENING) ##0
      hold_req_out
  ) else $error("start command did not open brake");

  chk_open_delay_len: assert property ( // RL12
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSED) ##1 (state_reg == MBS_OPENING) &&
      ($past(open_delay_in) == 16'h0002) |->
      (state_reg != MBS_OPEN) [*3]
  ) else $error("opening left before open delay");

  chk_delay_expiry: assert property ( // RL16
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSE_DELAY) && close_expired && brake_enable_in &&
      !start_cmd_in |=> (state_reg == MBS_CLOSED)
  ) else $error("expired close delay did not close");

  chk_speed_close: assert property ( // RL13
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_CLOSE_WAIT) && speed_below && brake_enable_in &&
      run_status_in && !start_cmd_in |=> (state_reg == MBS_CLOSE_DELAY)
  ) else $error("slow speed did not start close delay");

  chk_close_request: assert property ( // RL14
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == MBS_OPEN) && !start_cmd_in && run_status_in &&
      brake_enable_in |=> (state_reg == MBS_CLOSE_WAIT) ##0 ramp_req_out
  ) else $error("close request ignored in open state");

  chk_status_map: assert property ( // RL15
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    ##1 (brake_status_out == stat_of(state_reg)) &&
      (brake_status_out[`MBS_BIT_HOLD] == hold_req_out) &&
      (brake_status_out[`MBS_BIT_RAMP] == ramp_req_out)
  ) else $error("status word disagrees with state");

  chk_relay_bit: assert property ( // RL11
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    brake_open_out == brake_status_out[`MBS_BIT_OPEN]
  ) else $error("relay output differs from status bit 0");

endmodule

// [mbs_brake_seq_tb.sv]
// Self-checking bench for the brake sequencer with a reference model
`timescale 1ns/1ps
`include "mbs_defs.svh"

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end end

module mbs_brake_seq_tb
  import mbs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic st = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic [15:0] od = 16'h0000;
  logic [15:0] cd = 16'h0000;
  logic [15:0] lvl = 16'h0000;
  logic signed [15:0] tgt = 16'h0000;
  logic signed [15:0] speed;
  logic [4:0] stat;
  logic b_open, b_hold, b_ramp, b_en;
  logic [2:0] st_code;
  mbs_state_t exp_st;
  mbs_state_t ns;
  logic [4:0] exp_stat;
  logic [15:0] exp_cnt;
  logic exp_valid;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  mbs_brake_seq u_mbs_brake_seq (
    .ref_clk_in(clk), .sys_rst_in(rst), .brake_enable_in(en),
    .open_delay_in(od), .close_delay_in(cd), .close_level_in(lvl),
    .start_cmd_in(st), .run_status_in(run), .motor_speed_in(speed),
    .brake_status_out(stat), .brake_open_out(b_open),
    .hold_req_out(b_hold), .ramp_req_out(b_ramp), .enabled_out(b_en),
    .state_out(st_code)
  );

  mbs_drive_model u_mbs_drive_model (
    .ref_clk_in(clk), .sys_rst_in(rst), .hold_req_in(b_hold),
    .ramp_req_in(b_ramp), .target_in(tgt), .slow_in(slow),
    .speed_out(speed)
  );

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic below(logic signed [15:0] sp, logic [15:0] lv);
    int m;
    m = (sp < 0) ? -int'(sp) : int'(sp);
    return m < int'(lv);
  endfunction

  function automatic mbs_state_t nxt(mbs_state_t s, logic e, logic go,
      logic rn, logic xp, logic lo);
    if (!e) return MBS_DISABLED;
    case (s)
      MBS_DISABLED: return MBS_CLOSED;
      MBS_CLOSED: return (go && rn) ? MBS_OPENING : s;
      MBS_OPENING: return !rn ? MBS_CLOSE_DELAY : !go ? MBS_CLOSE_WAIT :
        xp ? MBS_OPEN : s;
      MBS_OPEN: return !rn ? MBS_CLOSE_DELAY : !go ? MBS_CLOSE_WAIT : s;
      MBS_CLOSE_WAIT: return !rn ? MBS_CLOSE_DELAY : go ? MBS_OPENING :
        lo ? MBS_CLOSE_DELAY : s;
      MBS_CLOSE_DELAY: return (go && rn) ? MBS_OPENING :
        xp ? MBS_CLOSED : s;
      default: return s;
    endcase
  endfunction

  function automatic logic [4:0] stat_of(mbs_state_t s);
    case (s)
      MBS_DISABLED: return 5'h01;
      MBS_OPENING: return 5'h15;
      MBS_OPEN: return 5'h11;
      MBS_CLOSE_WAIT: return 5'h19;
      MBS_CLOSE_DELAY: return 5'h18;
      default: return 5'h10;
    endcase
  endfunction

  always_comb ns = nxt(exp_st, en, st, run, exp_cnt == 16'h0000,
    below(speed, lvl));

  always_comb exp_stat = stat_of(exp_st);

  // Timer reloads on entry only, so a delay change mid-state is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_st <= MBS_CLOSED;
      exp_cnt <= 16'h0000;
      exp_valid <= 1'b0;
    end else begin
      exp_valid <= 1'b1;
      exp_st <= ns;
      if (ns != exp_st && ns == MBS_OPENING) begin
        exp_cnt <= od;
      end else if (ns != exp_st && ns == MBS_CLOSE_DELAY) begin
        exp_cnt <= cd;
      end else if (exp_cnt != 16'h0000) begin
        exp_cnt <= exp_cnt - 16'h0001;
      end
    end
  end

  always @(negedge clk) begin
    if (!rst && exp_valid) begin
      `CHK("state", 3'(exp_st), st_code)
      `CHK("status", exp_stat, stat)
      `CHK("open", exp_stat[0], b_open)
      `CHK("hold", exp_stat[2], b_hold)
      `CHK("ramp", exp_stat[3], b_ramp)
      `CHK("enabled", exp_stat[4], b_en)
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Directed plus random phases need well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic step(logic e, logic go, logic rn, logic [15:0] o,
      logic [15:0] c, logic [15:0] l, logic [15:0] t, logic sl, int n);
    @(posedge clk);
    en <= e;
    st <= go;
    run <= rn;
    od <= o;
    cd <= c;
    lvl <= l;
    tgt <= t;
    slow <= sl;
    repeat (n - 1) @(posedge clk);
  endtask

  task automatic pulse_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'hF0AE7820));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Corner cases: zero and longer delays, run loss, reopen, disable
    step(1'b0, 1'b1, 1'b1, 16'h0003, 16'h0002, 16'h0064, 16'h01F4, 0, 4);
    step(1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0064, 16'h01F4, 0, 6);
    step(1'b1, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0064, 16'h01F4, 0, 8);
    step(1'b1, 1'b1, 1'b1, 16'h0007, 16'h0005, 16'h0064, 16'h01F4, 0, 14);
    step(1'b1, 1'b1, 1'b0, 16'h0007, 16'h0005, 16'h0064, 16'h01F4, 0, 12);
    step(1'b1, 1'b1, 1'b1, 16'h0002, 16'h0005, 16'h0000, 16'h01F4, 0, 6);
    step(1'b1, 1'b0, 1'b1, 16'h0002, 16'h0005, 16'h0000, 16'h01F4, 0, 5);
    step(1'b1, 1'b1, 1'b1, 16'h0002, 16'h0005, 16'h0000, 16'h01F4, 0, 6);
    step(1'b1, 1'b1, 1'b1, 16'h0002, 16'h0003, 16'h8000, 16'h8000, 1, 4);
    step(1'b1, 1'b0, 1'b1, 16'h0002, 16'h0003, 16'h8000, 16'h8000, 1, 6);
    step(1'b0, 1'b0, 1'b1, 16'h0002, 16'h0003, 16'h8000, 16'h8000, 1, 3);
    // Random traffic with a reset in mid-run
    for (int i = 0; i < 6000; i++) begin
      if (i == 3000) begin
        pulse_reset();
      end
      @(posedge clk);
      en <= ($urandom % 64) != 0;
      run <= ($urandom % 24) != 0;
      if ($urandom % 10 == 0) begin
        st <= ~st;
      end
      od <= 16'($urandom % 8);
      cd <= 16'($urandom % 8);
      if ($urandom % 16 == 0) begin
        lvl <= 16'($urandom);
        tgt <= 16'($urandom);
        slow <= 1'($urandom);
      end
    end
    finish_test();
  end
endmodule

// [mbs_defs.svh]
// Constants for the mechanical brake sequencer: widths, bit positions, codes
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define MBS_STAT_W 5
`define MBS_SPEED_W 16
`define MBS_DELAY_W 16
`define MBS_STATE_W 3

// ----------------------------------------------------------------
// Brake status word bit positions (bit 1 is reserved, reads zero)
// ----------------------------------------------------------------
`define MBS_BIT_OPEN 0
`define MBS_BIT_HOLD 2
`define MBS_BIT_RAMP 3
`define MBS_BIT_EN 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MBS_STAT_RST 5'h10

// ----------------------------------------------------------------
// State codes, Gray along closed-opening-open-wait-delay
// ----------------------------------------------------------------
`define MBS_ST_CLOSED 3'h0
`define MBS_ST_OPENING 3'h1
`define MBS_ST_OPEN 3'h3
`define MBS_ST_CLOSE_WAIT 3'h2
`define MBS_ST_CLOSE_DELAY 3'h6
`define MBS_ST_DISABLED 3'h4

`endif

// [mbs_delay_timer.sv]
// Down-counting delay timer, reloaded on entry to a timed state
`timescale 1ns/1ps
`include "mbs_defs.svh"

module mbs_delay_timer #(
  parameter int DELAY_W = `MBS_DELAY_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic load_in,
  input wire logic [DELAY_W-1:0] delay_in,
  // Status
  output logic expired_out
);

  logic [DELAY_W-1:0] cnt_reg;

  // Reload wins over counting so a re-entry always restarts the delay
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
    end else if (load_in) begin
      cnt_reg <= delay_in;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Decoded from the count register alone so the state logic sees no loop through the load
  assign expired_out = (cnt_reg == '0);

endmodule

// [mbs_drive_model.sv]
// Behavioural drive speed loop that answers the brake sequencer's requests
`timescale 1ns/1ps

module mbs_drive_model #(
  parameter int STEP = 1000
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Requests from the sequencer
  input wire logic hold_req_in,
  input wire logic ramp_req_in,
  // Bench controls
  input wire logic signed [15:0] target_in,
  input wire logic slow_in,
  // Measured speed
  output logic signed [15:0] speed_out
);
  int s;
  int d;

  always_comb begin
    s = speed_out;
    d = slow_in ? 1 : STEP;
  end

  // ----------------------------------------------------------------
  // Speed loop
  // ----------------------------------------------------------------
  // Hold freezes the shaft speed; a slow ramp keeps the wait state busy
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      speed_out <= 16'h0000;
    end else if (ramp_req_in) begin
      if (s > d) begin
        speed_out <= 16'(s - d);
      end else if (s < -d) begin
        speed_out <= 16'(s + d);
      end else begin
        speed_out <= 16'h0000;
      end
    end else if (!hold_req_in) begin
      speed_out <= target_in;
    end
  end
endmodule

// [mbs_pkg.sv]
// Types shared by the mechanical brake sequencer modules
`include "mbs_defs.svh"

package mbs_pkg;

  typedef enum logic [`MBS_STATE_W-1:0] {
    MBS_CLOSED = `MBS_ST_CLOSED,
    MBS_OPENING = `MBS_ST_OPENING,
    MBS_OPEN = `MBS_ST_OPEN,
    MBS_CLOSE_WAIT = `MBS_ST_CLOSE_WAIT,
    MBS_CLOSE_DELAY = `MBS_ST_CLOSE_DELAY,
    MBS_DISABLED = `MBS_ST_DISABLED
  } mbs_state_t;

endpackage

// [mbs_speed_cmp.sv]
// Compares motor speed magnitude against the brake close level
`timescale 1ns/1ps
`include "mbs_defs.svh"

module mbs_speed_cmp #(
  parameter int SPEED_W = `MBS_SPEED_W
) (
  // Speed input, two's complement
  input wire logic signed [SPEED_W-1:0] speed_in,
  // Close level, unsigned magnitude
  input wire logic [SPEED_W-1:0] level_in,
  // Result
  output logic below_out
);

  // The most negative speed maps to its true unsigned magnitude
  function automatic logic [SPEED_W-1:0] magnitude(
    input logic signed [SPEED_W-1:0] s
  );
    logic [SPEED_W-1:0] m;
    m = s;
    if (s[SPEED_W-1]) begin
      m = SPEED_W'(~s + 1'b1);
    end
    return m;
  endfunction

  assign below_out = (magnitude(speed_in) < level_in);

endmodule
